//--- verilog/xie_ext_irq.sv
// extra external interrupts, control register, source arbiter, auxiliary port
// assumes the core masks by its own global enable and in-service state
//
// Summary of operation
// - control register at 0c0, bit addressable
// - bits: priority, enable, flag, type per input
// - priority bit selects high level
// - request taken only while enabled
// - type one falling edge, zero low level
// - edge flag set by hardware, cleared on service
// - added inputs behave like standard ones
// - eight vectors, fixed polling order within level
// - auxiliary port at 0d8, low four bits
// - port latch byte and bit accessible
// - port bits two, three feed interrupts
// - pins quasi bidirectional with pull-ups
// - port latch resets to all ones
// - control register resets to zero
`timescale 1ns/10ps
module xie_ext_irq (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// byte register path
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_rd,
	output logic [7:0] sfr_rdata,
	// bit register path
	input wire logic [7:0] bit_addr,
	input wire logic bit_wr,
	input wire logic bit_wval,
	input wire logic bit_rd,
	output logic bit_rdata,
	// standard sources from the core, already enabled
	input wire logic [5:0] std_req,
	input wire logic [5:0] std_high,
	input wire logic irq_ack,
	input wire logic [2:0] irq_ack_src,
	// arbiter result
	output logic irq_req,
	output logic irq_high,
	output logic [2:0] irq_src,
	output logic [7:0] irq_vec,
	// auxiliary port pins
	input wire logic [3:0] port_in,
	output logic [3:0] port_out,
	output logic [3:0] port_oe_n
);
	typedef struct packed {
		logic [7:0] ctl;
		logic [3:0] latch;
		logic [7:0] rdata;
		logic bdata;
		logic req;
		logic high;
		logic [2:0] src;
		logic [7:0] vec;
	} xie_state_t;

	xie_state_t s_reg;
	xie_state_t s_next;
	xie_pin_if pin ();

	// ========================================
	// pin conditioning
	xie_pin_sync u_sync (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.port_in(port_in),
		.pin(pin)
	);

	// ========================================
	// helpers
	function automatic logic [2:0] xie_first(input logic [7:0] v);
		logic [2:0] idx;
		idx = 3'h0;
		for (int i = xie_pkg::XIE_NSRC - 1; i >= 0; i--) begin
			if (v[i]) begin
				idx = 3'(i);
			end
		end
		return idx;
	endfunction

	logic [7:0] pend;
	logic [7:0] pend_high;
	logic [2:0] pick;
	logic ctl_wr;
	logic ctl_bit_wr;
	logic port_bit_wr;

	always_comb begin
		pend = {s_reg.ctl[xie_pkg::XIE_FLG3] & s_reg.ctl[xie_pkg::XIE_ENA3],
			s_reg.ctl[xie_pkg::XIE_FLG2] & s_reg.ctl[xie_pkg::XIE_ENA2],
			std_req};
		pend_high = pend & {s_reg.ctl[xie_pkg::XIE_PRI3], s_reg.ctl[xie_pkg::XIE_PRI2],
			std_high};
		pick = (|pend_high) ? xie_first(pend_high) : xie_first(pend);
		ctl_wr = sfr_wr && sfr_addr == xie_pkg::XIE_CTL_ADDR;
		ctl_bit_wr = bit_wr && bit_addr[7:3] == xie_pkg::XIE_CTL_BITBASE;
		port_bit_wr = bit_wr && bit_addr[7:2] == {xie_pkg::XIE_PORT_BITBASE, 1'b0};
	end

	// ========================================
	// next state
	always_comb begin
		s_next = s_reg;
		if (clk_en) begin
			if (ctl_wr) begin
				s_next.ctl = sfr_wdata;
			end
			if (ctl_bit_wr) begin
				s_next.ctl[bit_addr[2:0]] = bit_wval;
			end
			if (sfr_wr && sfr_addr == xie_pkg::XIE_PORT_ADDR) begin
				s_next.latch = sfr_wdata[3:0];
			end
			if (port_bit_wr) begin
				s_next.latch[bit_addr[1:0]] = bit_wval;
			end
			// input two: clear on service, then set wins
			if (s_reg.ctl[xie_pkg::XIE_SEL2]) begin
				if (irq_ack && irq_ack_src == xie_pkg::XIE_SRC_EXT2) begin
					s_next.ctl[xie_pkg::XIE_FLG2] = 1'b0;
				end
				if (pin.fall[xie_pkg::XIE_PIN_TWO]) begin
					s_next.ctl[xie_pkg::XIE_FLG2] = 1'b1;
				end
			end else begin
				s_next.ctl[xie_pkg::XIE_FLG2] = ~pin.lvl[xie_pkg::XIE_PIN_TWO];
			end
			// input three: same scheme
			if (s_reg.ctl[xie_pkg::XIE_SEL3]) begin
				if (irq_ack && irq_ack_src == xie_pkg::XIE_SRC_EXT3) begin
					s_next.ctl[xie_pkg::XIE_FLG3] = 1'b0;
				end
				if (pin.fall[xie_pkg::XIE_PIN_THREE]) begin
					s_next.ctl[xie_pkg::XIE_FLG3] = 1'b1;
				end
			end else begin
				s_next.ctl[xie_pkg::XIE_FLG3] = ~pin.lvl[xie_pkg::XIE_PIN_THREE];
			end
			// read data
			s_next.rdata = 8'h00;
			if (sfr_rd && sfr_addr == xie_pkg::XIE_CTL_ADDR) begin
				s_next.rdata = s_reg.ctl;
			end else if (sfr_rd && sfr_addr == xie_pkg::XIE_PORT_ADDR) begin
				s_next.rdata = {4'h0, pin.lvl};
			end
			s_next.bdata = 1'b0;
			if (bit_rd && bit_addr[7:3] == xie_pkg::XIE_CTL_BITBASE) begin
				s_next.bdata = s_reg.ctl[bit_addr[2:0]];
			end else if (bit_rd && bit_addr[7:2] == {xie_pkg::XIE_PORT_BITBASE, 1'b0}) begin
				s_next.bdata = pin.lvl[bit_addr[1:0]];
			end
			// arbiter
			s_next.req = |pend;
			s_next.high = |pend_high;
			s_next.src = pick;
			s_next.vec = xie_pkg::XIE_VEC_BASE + {2'b00, pick, 3'b000};
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= '{ctl: xie_pkg::XIE_CTL_RESET,
				latch: xie_pkg::XIE_PORT_RESET,
				rdata: 8'h00, bdata: 1'b0, req: 1'b0, high: 1'b0,
				src: 3'h0, vec: xie_pkg::XIE_VEC_BASE};
		end else begin
			s_reg <= s_next;
		end
	end

	// ========================================
	// outputs
	assign sfr_rdata = s_reg.rdata;
	assign bit_rdata = s_reg.bdata;
	assign irq_req = s_reg.req;
	assign irq_high = s_reg.high;
	assign irq_src = s_reg.src;
	assign irq_vec = s_reg.vec;
	assign port_out = 4'h0;
	assign port_oe_n = s_reg.latch;

	// ========================================
	// checks
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_edge2_fall;
		clk_en && s_reg.ctl[xie_pkg::XIE_SEL2] && pin.fall[xie_pkg::XIE_PIN_TWO];
	endsequence
	sequence s_edge3_served;
		clk_en && s_reg.ctl[xie_pkg::XIE_SEL3] && !ctl_wr && !ctl_bit_wr &&
			irq_ack && irq_ack_src == xie_pkg::XIE_SRC_EXT3 &&
			!pin.fall[xie_pkg::XIE_PIN_THREE];
	endsequence

	AST_EDGE_SET: assert property (s_edge2_fall |=> s_reg.ctl[xie_pkg::XIE_FLG2])
		else $error("edge flag two not set");
	AST_SERVICE_CLEAR: assert property (s_edge3_served |=> !s_reg.ctl[xie_pkg::XIE_FLG3])
		else $error("edge flag three not cleared on service");
	AST_LEVEL_FOLLOW: assert property (clk_en && !s_reg.ctl[xie_pkg::XIE_SEL3]
		|=> s_reg.ctl[xie_pkg::XIE_FLG3] == !$past(pin.lvl[xie_pkg::XIE_PIN_THREE]))
		else $error("level flag three does not follow pin");
	AST_DISABLED_QUIET: assert property (clk_en && std_req == 6'h00 &&
		!s_reg.ctl[xie_pkg::XIE_ENA2] && !s_reg.ctl[xie_pkg::XIE_ENA3] |=> !irq_req)
		else $error("request raised while all sources disabled");
	AST_VEC_FORM: assert property (irq_req |-> irq_vec == {2'b00, irq_src, 3'b011})
		else $error("vector does not match source");
	AST_HIGH_FIRST: assert property (clk_en && std_req[0] && std_high[0]
		|=> irq_req && irq_high && irq_vec == 8'h03)
		else $error("high ext0 not chosen first");
	AST_EXT3_HIGH: assert property (clk_en && s_reg.ctl[7:5] == 3'h7 &&
		(std_req & std_high) == 6'h00 && !(pend_high[6])
		|=> irq_high && irq_vec == 8'h3b)
		else $error("high input three not chosen");
	AST_PORT_WRITE: assert property (clk_en && sfr_wr && sfr_addr == 8'hd8 &&
		!port_bit_wr |=> port_oe_n == $past(sfr_wdata[3:0]))
		else $error("port latch not written");
	AST_RESET_VAL: assert property ($rose(rst_n) |-> s_reg.ctl == 8'h00 &&
		port_oe_n == 4'hf)
		else $error("reset values wrong");
endmodule

//--- verilog/xie_pkg.sv
// constants for the extra external interrupt and auxiliary port block
// assumes an 8-bit core with a byte and a bit special-function path
package xie_pkg;
	// ========================================
	// addresses
	localparam logic [7:0] XIE_CTL_ADDR = 8'hc0;
	localparam logic [7:0] XIE_PORT_ADDR = 8'hd8;
	localparam logic [4:0] XIE_CTL_BITBASE = 5'h18;
	localparam logic [4:0] XIE_PORT_BITBASE = 5'h1b;
	// ========================================
	// control register fields
	localparam int XIE_SEL2 = 0;
	localparam int XIE_FLG2 = 1;
	localparam int XIE_ENA2 = 2;
	localparam int XIE_PRI2 = 3;
	localparam int XIE_SEL3 = 4;
	localparam int XIE_FLG3 = 5;
	localparam int XIE_ENA3 = 6;
	localparam int XIE_PRI3 = 7;
	// ========================================
	// reset values
	localparam logic [7:0] XIE_CTL_RESET = 8'h00;
	localparam logic [3:0] XIE_PORT_RESET = 4'hf;
	// ========================================
	// sources and vectors
	localparam int XIE_NSRC = 8;
	localparam logic [2:0] XIE_SRC_EXT2 = 3'h6;
	localparam logic [2:0] XIE_SRC_EXT3 = 3'h7;
	localparam logic [7:0] XIE_VEC_BASE = 8'h03;
	localparam int XIE_PIN_TWO = 2;
	localparam int XIE_PIN_THREE = 3;
endpackage

//--- verilog/xie_pin_if.sv
// carrier between the pin conditioner and the main block
// assumes both ends run on core_clk
`timescale 1ns/10ps
interface xie_pin_if;
	logic [3:0] lvl;
	logic [3:0] fall;
	modport cond (output lvl, output fall);
	modport user (input lvl, input fall);
endinterface

//--- verilog/xie_pin_sync.sv
// two-stage synchroniser and falling edge finder for the auxiliary pins
// assumes pins may change at any time relative to core_clk
`timescale 1ns/10ps
module xie_pin_sync (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// pins and conditioned view
	input wire logic [3:0] port_in,
	xie_pin_if.cond pin
);
	typedef struct packed {
		logic [3:0] stage_a;
		logic [3:0] stage_b;
		logic [3:0] stage_c;
	} xie_sync_t;

	xie_sync_t s_reg;
	xie_sync_t s_next;

	// ========================================
	// next state
	always_comb begin
		s_next = s_reg;
		if (clk_en) begin
			s_next.stage_a = port_in;
			s_next.stage_b = s_reg.stage_a;
			s_next.stage_c = s_reg.stage_b;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= '{stage_a: 4'hf, stage_b: 4'hf, stage_c: 4'hf};
		end else begin
			s_reg <= s_next;
		end
	end

	assign pin.lvl = s_reg.stage_b;
	assign pin.fall = s_reg.stage_c & ~s_reg.stage_b;
endmodule

//--- sim/xie_pin_model.sv
// pull-up pin model for the auxiliary port
// assumes open-drain style enables from the block
`timescale 1ns/10ps
module xie_pin_model (
	// block side
	input wire logic [3:0] port_out,
	input wire logic [3:0] port_oe_n,
	// far side pulls pins low
	input wire logic [3:0] ext_low,
	output logic [3:0] port_in
);
	// ========================================
	// wired level with pull-up
	always_comb begin
		port_in = ~ext_low & (port_oe_n | port_out);
	end
endmodule

//--- sim/xie_ext_irq_bench.sv
// bench for the extra interrupt and auxiliary port block
// assumes the pin model pulls released pins high
`timescale 1ns/10ps
module xie_ext_irq_bench;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] sfr_addr = 8'h00;
	logic [7:0] sfr_wdata = 8'h00;
	logic [7:0] bit_addr = 8'h00;
	logic sfr_wr = 1'b0;
	logic sfr_rd = 1'b0;
	logic bit_wr = 1'b0;
	logic bit_wval = 1'b0;
	logic bit_rd = 1'b0;
	logic [5:0] std_req = 6'h00;
	logic [5:0] std_high = 6'h00;
	logic irq_ack = 1'b0;
	logic [2:0] irq_ack_src = 3'h0;
	logic [3:0] ext_low = 4'h0;
	logic clk_en = 1'b1;
	logic [7:0] sfr_rdata, irq_vec, v;
	logic bit_rdata, irq_req, irq_high;
	logic [2:0] irq_src;
	logic [3:0] port_in, port_out, port_oe_n;
	int failures = 0;
	int tests_run = 0;
	int cycles = 0;
	// ========================================
	// clock, design and partner
	always #50 core_clk = ~core_clk;
	xie_ext_irq dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
		.sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd),
		.sfr_rdata(sfr_rdata), .bit_addr(bit_addr), .bit_wr(bit_wr), .bit_wval(bit_wval),
		.bit_rd(bit_rd), .bit_rdata(bit_rdata), .std_req(std_req), .std_high(std_high),
		.irq_ack(irq_ack), .irq_ack_src(irq_ack_src), .irq_req(irq_req),
		.irq_high(irq_high), .irq_src(irq_src), .irq_vec(irq_vec), .port_in(port_in),
		.port_out(port_out), .port_oe_n(port_oe_n));
	xie_pin_model pins (.port_out(port_out), .port_oe_n(port_oe_n), .ext_low(ext_low),
		.port_in(port_in));
	// ========================================
	// access and compare tasks
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge core_clk);
		sfr_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge core_clk);
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(negedge core_clk);
		sfr_rd = 1'b0;
		d = sfr_rdata;
	endtask
	task automatic bw(input logic [7:0] a, input logic b);
		@(negedge core_clk);
		bit_addr = a;
		bit_wval = b;
		bit_wr = 1'b1;
		@(negedge core_clk);
		bit_wr = 1'b0;
	endtask
	task automatic br(input logic [7:0] a, output logic [7:0] d);
		@(negedge core_clk);
		bit_addr = a;
		bit_rd = 1'b1;
		@(negedge core_clk);
		bit_rd = 1'b0;
		d = {7'h00, bit_rdata};
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("FAIL t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic pause(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic report_and_stop;
		if (failures == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// ========================================
	// hang guard
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			report_and_stop;
		end
	end
	// ========================================
	// tests
	initial begin
		pause(16);
		rst_n = 1'b1;
		rd(8'hc0, v);
		chk(v, xie_pkg::XIE_CTL_RESET);
		rd(8'hd8, v);
		chk(v, 8'h0f);
		chk({port_out, port_oe_n}, 8'h0f);
		wr(8'hd8, 8'h0a);
		pause(2);
		rd(8'hd8, v);
		chk(v, 8'h0a);
		bw(8'hd8, 1'b1);
		pause(2);
		rd(8'hd8, v);
		chk(v, 8'h0b);
		chk({port_out, port_oe_n}, 8'h0b);
		br(8'hda, v);
		chk(v, 8'h00);
		br(8'hd9, v);
		chk(v, 8'h01);
		wr(8'hd8, 8'h0f);
		rd(8'h55, v);
		chk(v, 8'h00);
		bw(8'hc2, 1'b1);
		rd(8'hc0, v);
		chk(v, 8'h04);
		br(8'hc2, v);
		chk(v, 8'h01);
		for (int i = 0; i < 6; i++) begin
			@(negedge core_clk);
			std_req = 6'h01 << i;
			pause(3);
			chk(irq_vec, 8'h03 + 8'(8 * i));
		end
		std_req = 6'h01;
		std_high = 6'h01;
		pause(2);
		chk({irq_req, irq_high, 3'h0, irq_src}, 8'hc0);
		chk(irq_vec, 8'h03);
		std_req = 6'h00;
		std_high = 6'h00;
		wr(8'hc0, 8'h05);
		ext_low = 4'h4;
		pause(6);
		chk({irq_req, irq_high, 3'h0, irq_src}, 8'h86);
		chk(irq_vec, 8'h33);
		ext_low = 4'h0;
		rd(8'hc0, v);
		chk(v, 8'h07);
		irq_ack_src = 3'h6;
		irq_ack = 1'b1;
		pause(1);
		irq_ack = 1'b0;
		pause(3);
		rd(8'hc0, v);
		chk(v, 8'h05);
		chk({7'h00, irq_req}, 8'h00);
		wr(8'hc0, 8'hc0);
		std_req = 6'h01;
		ext_low = 4'h8;
		pause(6);
		chk({irq_req, irq_high, 3'h0, irq_src}, 8'hc7);
		chk(irq_vec, 8'h3b);
		rd(8'hc0, v);
		chk(v, 8'he0);
		bw(8'hc7, 1'b0);
		pause(3);
		chk({irq_req, irq_high, 3'h0, irq_src}, 8'h80);
		ext_low = 4'h0;
		std_req = 6'h00;
		pause(6);
		rd(8'hc0, v);
		chk(v, 8'h40);
		chk({7'h00, irq_req}, 8'h00);
		wr(8'hc0, 8'h01);
		ext_low = 4'h4;
		pause(6);
		chk({7'h00, irq_req}, 8'h00);
		rd(8'hc0, v);
		chk(v, 8'h03);
		ext_low = 4'h0;
		wr(8'hc0, 8'h50);
		ext_low = 4'h8;
		pause(6);
		chk({irq_req, irq_high, 3'h0, irq_src}, 8'h87);
		irq_ack_src = 3'h7;
		irq_ack = 1'b1;
		pause(1);
		irq_ack = 1'b0;
		pause(3);
		rd(8'hc0, v);
		chk(v, 8'h50);
		chk({7'h00, irq_req}, 8'h00);
		ext_low = 4'h0;
		clk_en = 1'b0;
		wr(8'hc0, 8'hff);
		clk_en = 1'b1;
		rd(8'hc0, v);
		chk(v, 8'h50);
		wr(8'hd8, 8'h00);
		chk({port_out, port_oe_n}, 8'h00);
		rst_n = 1'b0;
		pause(2);
		rst_n = 1'b1;
		chk({port_out, port_oe_n}, 8'h0f);
		rd(8'hc0, v);
		chk(v, xie_pkg::XIE_CTL_RESET);
		chk({7'h00, irq_req}, 8'h00);
		report_and_stop;
	end
endmodule
